/* rtl/dcwit_map.svh */
// offsets, field positions, reset values and timing counts of the
// two-channel watchdog / interval timer; definitions only
`ifndef DCWIT_MAP_SVH
`define DCWIT_MAP_SVH

`define DCWIT_CH0_CSR_ADDR 16'hffa8
`define DCWIT_CH0_CNT_ADDR 16'hffa9
`define DCWIT_SYSCTL_ADDR 16'hffc4
`define DCWIT_CH1_CSR_ADDR 16'hffea
`define DCWIT_CH1_CNT_ADDR 16'hffeb

`define DCWIT_KEY_COUNT 8'h5a
`define DCWIT_KEY_CTRL 8'ha5

`define DCWIT_CSR_RESET 8'h00
`define DCWIT_CNT_RESET 8'h00
`define DCWIT_SYSCTL_RESET 8'h09
`define DCWIT_SYSCTL_WMASK 8'hd7
`define DCWIT_SYSCTL_XRST 3
`define DCWIT_CNT_MAX 8'hff

`define DCWIT_BIT_OVF 7
`define DCWIT_BIT_RUN 5

// internal reset length in system clock cycles
`define DCWIT_RESET_CYCLES 10'd518

// system prescaler divide exponents, codes 0..7
`define DCWIT_SYS_SHIFT_0 5'd1
`define DCWIT_SYS_SHIFT_1 5'd6
`define DCWIT_SYS_SHIFT_2 5'd7
`define DCWIT_SYS_SHIFT_3 5'd9
`define DCWIT_SYS_SHIFT_4 5'd11
`define DCWIT_SYS_SHIFT_5 5'd13
`define DCWIT_SYS_SHIFT_6 5'd15
`define DCWIT_SYS_SHIFT_7 5'd17
`define DCWIT_SYS_PRE_W 17
`define DCWIT_SUB_PRE_W 8

`endif

/* rtl/dcwit_pkg.sv */
// types shared by the watchdog / interval timer
// assumes the map header is compiled alongside
package dcwit_pkg;

  typedef struct packed {
    logic ovf;
    logic mode;
    logic run;
    logic src;
    logic rst_sel;
    logic [2:0] cks;
  } dcwit_csr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic word;
    logic rd;
  } dcwit_bus_req_t;

  typedef enum logic [1:0] {
    DCWIT_RS_IDLE = 2'b01,
    DCWIT_RS_HOLD = 2'b10
  } dcwit_rst_state_t;

endpackage

/* rtl/dcwit_top.sv */
// two-channel watchdog / interval timer with keyed word writes
// assumes a synchronous cpu register port and a subclock pin already
// synchronous to ref_clk
`timescale 1ns/100ps
`include "dcwit_map.svh"

module dcwit_top
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // power state
  input wire logic hw_standby,
  input wire logic sw_standby,
  // subclock pin
  input wire logic ext_subclock_pin,
  // register port
  input wire dcwit_pkg::dcwit_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // events
  output logic [1:0] interval_overflow_irq,
  output logic [1:0] nmi_req,
  output logic wdt_reset_req,
  output logic chip_reset_out
);
  import dcwit_pkg::*;

  // low k bits of a prescaler all ones means its bit k-1 falls next
  function automatic logic sys_tick(input logic [16:0] pre,
                                    input logic [2:0] cks);
    logic [4:0] k;
    logic [16:0] mask;
    k = `DCWIT_SYS_SHIFT_0;
    unique case (cks)
      3'h0: k = `DCWIT_SYS_SHIFT_0;
      3'h1: k = `DCWIT_SYS_SHIFT_1;
      3'h2: k = `DCWIT_SYS_SHIFT_2;
      3'h3: k = `DCWIT_SYS_SHIFT_3;
      3'h4: k = `DCWIT_SYS_SHIFT_4;
      3'h5: k = `DCWIT_SYS_SHIFT_5;
      3'h6: k = `DCWIT_SYS_SHIFT_6;
      3'h7: k = `DCWIT_SYS_SHIFT_7;
    endcase
    mask = (17'h00001 << k) - 17'h00001;
    return (pre & mask) == mask;
  endfunction

  function automatic logic sub_tick(input logic [7:0] pre,
                                    input logic [2:0] cks);
    logic [7:0] mask;
    mask = (8'h02 << cks) - 8'h01;
    return (pre & mask) == mask;
  endfunction

  // state
  dcwit_csr_t csr [2];
  dcwit_csr_t next_csr [2];
  logic [7:0] cnt [2];
  logic [7:0] next_cnt [2];
  logic [1:0] armed;
  logic [1:0] next_armed;
  logic [16:0] sys_pre;
  logic [16:0] next_sys_pre;
  logic [7:0] sub_pre;
  logic [7:0] next_sub_pre;
  logic sub_last;
  logic [7:0] sysctl;
  logic [7:0] next_sysctl;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [1:0] next_irq;
  logic [1:0] next_nmi;
  logic next_reset_req;
  dcwit_rst_state_t rs_state;
  dcwit_rst_state_t next_rs_state;
  logic [9:0] rs_count;
  logic [9:0] next_rs_count;
  logic next_chip_reset;

  logic sub_edge;
  logic sys_run;
  logic word_wr;
  logic [7:0] key;
  logic [15:0] wr_addr [2];
  logic [15:0] cnt_addr [2];

  assign wr_addr[0] = `DCWIT_CH0_CSR_ADDR;
  assign wr_addr[1] = `DCWIT_CH1_CSR_ADDR;
  assign cnt_addr[0] = `DCWIT_CH0_CNT_ADDR;
  assign cnt_addr[1] = `DCWIT_CH1_CNT_ADDR;
  assign sub_edge = ext_subclock_pin & ~sub_last;
  // software standby stops the system clock tree, so its prescaler halts
  assign sys_run = ~sw_standby;
  assign word_wr = bus_req.wr & bus_req.word;
  assign key = bus_req.wdata[15:8];

  // prescalers run free from reset; only taps are selected per channel
  always_comb
  begin
    next_sys_pre = sys_pre;
    next_sub_pre = sub_pre;
    if (sys_run)
    begin
      next_sys_pre = sys_pre + 17'h00001;
    end
    if (sub_edge)
    begin
      next_sub_pre = sub_pre + 8'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || hw_standby)
    begin
      sys_pre <= 17'h00000;
      sub_pre <= 8'h00;
      sub_last <= 1'b0;
    end
    else
    begin
      sys_pre <= next_sys_pre;
      sub_pre <= next_sub_pre;
      sub_last <= ext_subclock_pin;
    end
  end

  // channels, register port and events
  always_comb
  begin
    logic tick;
    logic ovf_now;
    logic csr_wr;
    logic cnt_wr;
    logic clr;
    tick = 1'b0;
    ovf_now = 1'b0;
    csr_wr = 1'b0;
    cnt_wr = 1'b0;
    clr = 1'b0;
    next_irq = 2'b00;
    next_nmi = 2'b00;
    next_reset_req = 1'b0;
    next_rdata = 8'h00;
    next_rvalid = bus_req.rd;
    next_sysctl = sysctl;
    for (int ch = 0; ch < 2; ch++)
    begin
      next_csr[ch] = csr[ch];
      next_cnt[ch] = cnt[ch];
      next_armed[ch] = armed[ch];
      if (ch == 1 && csr[ch].src)
      begin
        tick = sub_edge && sub_tick(sub_pre, csr[ch].cks);
      end
      else
      begin
        tick = sys_run && sys_tick(sys_pre, csr[ch].cks);
      end
      csr_wr = word_wr && bus_req.addr == wr_addr[ch] &&
               key == `DCWIT_KEY_CTRL;
      cnt_wr = word_wr && bus_req.addr == wr_addr[ch] &&
               key == `DCWIT_KEY_COUNT;
      ovf_now = 1'b0;
      if (!csr[ch].run)
      begin
        next_cnt[ch] = 8'h00;
      end
      else if (cnt_wr)
      begin
        next_cnt[ch] = bus_req.wdata[7:0];
      end
      else if (tick)
      begin
        next_cnt[ch] = cnt[ch] + 8'h01;
        ovf_now = cnt[ch] == `DCWIT_CNT_MAX;
      end
      clr = 1'b0;
      if (csr_wr)
      begin
        next_csr[ch] = bus_req.wdata[7:0];
        next_csr[ch].ovf = csr[ch].ovf;
        // a zero after an armed read clears; a write with run zero clears too
        clr = !bus_req.wdata[`DCWIT_BIT_OVF] && armed[ch];
        if (!bus_req.wdata[`DCWIT_BIT_RUN])
        begin
          clr = 1'b1;
          next_cnt[ch] = 8'h00;
        end
        next_armed[ch] = 1'b0;
      end
      clr = clr || (rs_state == DCWIT_RS_HOLD && csr[ch].mode &&
                    csr[ch].rst_sel);
      if (clr)
      begin
        next_csr[ch].ovf = 1'b0;
      end
      // set wins over any clear in the same cycle
      if (ovf_now)
      begin
        next_csr[ch].ovf = 1'b1;
        if (!csr[ch].mode)
        begin
          next_irq[ch] = 1'b1;
        end
        else if (csr[ch].rst_sel)
        begin
          next_reset_req = 1'b1;
        end
        else
        begin
          next_nmi[ch] = 1'b1;
        end
      end
      if (bus_req.rd && bus_req.addr == wr_addr[ch])
      begin
        next_rdata = csr[ch];
        next_armed[ch] = next_armed[ch] | csr[ch].ovf;
      end
      if (bus_req.rd && bus_req.addr == cnt_addr[ch])
      begin
        next_rdata = cnt[ch];
      end
    end
    if (bus_req.rd && bus_req.addr == `DCWIT_SYSCTL_ADDR)
    begin
      next_rdata = sysctl;
    end
    if (bus_req.wr && bus_req.addr == `DCWIT_SYSCTL_ADDR)
    begin
      next_sysctl = (sysctl & ~`DCWIT_SYSCTL_WMASK) |
                    (bus_req.wdata[7:0] & `DCWIT_SYSCTL_WMASK);
    end
    // reset source marker falls on a watchdog reset; external reset sets it
    if (next_reset_req)
    begin
      next_sysctl[`DCWIT_SYSCTL_XRST] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    // cleared by reset and hardware standby only
    if (rst || hw_standby)
    begin
      for (int ch = 0; ch < 2; ch++)
      begin
        csr[ch] <= `DCWIT_CSR_RESET;
        cnt[ch] <= `DCWIT_CNT_RESET;
      end
      armed <= 2'b00;
      sysctl <= `DCWIT_SYSCTL_RESET;
      bus_rdata <= 8'h00;
      bus_rvalid <= 1'b0;
      interval_overflow_irq <= 2'b00;
      nmi_req <= 2'b00;
      wdt_reset_req <= 1'b0;
    end
    else
    begin
      for (int ch = 0; ch < 2; ch++)
      begin
        csr[ch] <= next_csr[ch];
        cnt[ch] <= next_cnt[ch];
      end
      armed <= next_armed;
      sysctl <= next_sysctl;
      bus_rdata <= next_rdata;
      bus_rvalid <= next_rvalid;
      interval_overflow_irq <= next_irq;
      nmi_req <= next_nmi;
      wdt_reset_req <= next_reset_req;
    end
  end

  // internal reset stretcher; a request during hold is absorbed
  always_comb
  begin
    next_rs_state = rs_state;
    next_rs_count = rs_count;
    unique case (rs_state)
      DCWIT_RS_IDLE:
      begin
        if (wdt_reset_req)
        begin
          next_rs_state = DCWIT_RS_HOLD;
          next_rs_count = `DCWIT_RESET_CYCLES - 10'd1;
        end
      end
      DCWIT_RS_HOLD:
      begin
        if (rs_count == 10'd0)
        begin
          next_rs_state = DCWIT_RS_IDLE;
        end
        else
        begin
          next_rs_count = rs_count - 10'd1;
        end
      end
      default:
      begin
        next_rs_state = DCWIT_RS_IDLE;
      end
    endcase
    next_chip_reset = next_rs_state == DCWIT_RS_HOLD;
  end

  always_ff @(posedge ref_clk)
  begin
    // hold the chip reset 518 cycles
    if (rst || hw_standby)
    begin
      rs_state <= DCWIT_RS_IDLE;
      rs_count <= 10'd0;
      chip_reset_out <= 1'b0;
    end
    else
    begin
      rs_state <= next_rs_state;
      rs_count <= next_rs_count;
      chip_reset_out <= next_chip_reset;
    end
  end

endmodule

/* tb/dcwit_chk.sv */
// port checker for the two-channel timer
// assumes it is bound into dcwit_top
`timescale 1ns/100ps
module dcwit_chk
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hw_standby,
  // register port
  input wire dcwit_pkg::dcwit_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  // events
  input wire logic [1:0] interval_overflow_irq,
  input wire logic [1:0] nmi_req,
  input wire logic wdt_reset_req,
  input wire logic chip_reset_out
);
  import dcwit_pkg::*;
  logic clr;
  logic [9:0] rlen;
  logic [9:0] next_rlen;
  assign clr = rst | hw_standby;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (clr);
  // length of the current stretched reset
  always_comb
  begin
    next_rlen = chip_reset_out ? rlen + 10'd1 : 10'd0;
    if (clr)
    begin
      next_rlen = 10'd0;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    rlen <= next_rlen;
  end
  rd_answer_a:
    assert property (bus_req.rd |=> bus_rvalid)
      else $error("read not answered");
  rvalid_cause_a:
    assert property (bus_rvalid |-> $past(bus_req.rd))
      else $error("read answer without read");
  rdata_idle_a:
    assert property (!bus_rvalid |-> bus_rdata == 8'h00)
      else $error("read data outside answer");
  irq_single_a:
    assert property ((interval_overflow_irq
      & $past(interval_overflow_irq)) == 2'b00)
      else $error("interval request longer than one cycle");
  nmi_single_a:
    assert property (|nmi_req |=> (nmi_req & $past(nmi_req)) == 2'b00)
      else $error("nmi request longer than one cycle");
  stretch_start_a:
    assert property (wdt_reset_req |=> chip_reset_out && !wdt_reset_req)
      else $error("stretched reset did not start");
  stretch_len_a:
    assert property ($fell(chip_reset_out) && !$past(clr)
      |-> rlen == 10'd518)
      else $error("stretched reset length wrong");
  reset_quiet_a:
    assert property (disable iff (1'b0) clr |=> !bus_rvalid
      && !chip_reset_out && nmi_req == 2'b00
      && interval_overflow_irq == 2'b00 && !wdt_reset_req)
      else $error("outputs active after reset");
  irq_seen_c: cover property (interval_overflow_irq[1]);
  nmi_seen_c: cover property (nmi_req[1]);
  hold_seen_c: cover property ($rose(chip_reset_out));
endmodule

bind dcwit_top dcwit_chk u_chk
(
  .ref_clk(ref_clk), .rst(rst), .hw_standby(hw_standby),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
  .interval_overflow_irq(interval_overflow_irq), .nmi_req(nmi_req),
  .wdt_reset_req(wdt_reset_req), .chip_reset_out(chip_reset_out)
);

/* tb/dcwit_cpu_model.sv */
// cpu-side master of the timer register port
// assumes callers are clocked by ref_clk
`timescale 1ns/100ps
module dcwit_cpu_model
(
  // clock
  input wire logic ref_clk,
  // register port
  output dcwit_pkg::dcwit_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid
);
  import dcwit_pkg::*;
  initial bus_req = '0;
  task automatic wr16(input logic [15:0] a, input logic [15:0] d,
    input logic w);
  begin
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, word: w, rd: 1'b0};
    @(posedge ref_clk);
    // released lines show the inverse, never a stale match
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, word: 1'b0, rd: 1'b0};
  end
  endtask
  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
  begin
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, word: 1'b0,
      rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, word: 1'b0,
      rd: 1'b0};
    #1;
    d = bus_rvalid ? bus_rdata : 8'hxx;
  end
  endtask
endmodule

/* tb/dcwit_bench.sv */
// self-checking bench for the two-channel timer
// assumes the cpu model and checker are compiled first
`timescale 1ns/100ps
module dcwit_bench;
  import dcwit_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic ext_subclock_pin = 1'b0;
  logic [2:0] sub_div = 3'h0;
  dcwit_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic bus_rvalid;
  logic [1:0] irq;
  logic [1:0] nmi;
  logic wrr;
  logic cro;
  logic [5:0] ev;
  int num_errors = 0;
  int total_checks = 0;
  assign ev = {cro, wrr, nmi, irq};
  always #4 ref_clk = ~ref_clk;
  // subclock at an eighth of the system clock
  always @(posedge ref_clk)
  begin
    sub_div <= sub_div + 3'h1;
    ext_subclock_pin <= sub_div[2];
  end
  dcwit_top u_dut
  (
    .ref_clk(ref_clk), .rst(rst), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .ext_subclock_pin(ext_subclock_pin),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .interval_overflow_irq(irq), .nmi_req(nmi),
    .wdt_reset_req(wrr), .chip_reset_out(cro)
  );
  dcwit_cpu_model u_cpu
  (
    .ref_clk(ref_clk), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid)
  );
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
  begin
    u_cpu.rd8(a, d);
    check8(d, exp);
  end
  endtask
  // bounded wait for one event pulse
  task automatic wait_ev(input int k, input int lim);
    int n;
  begin
    n = 0;
    while (ev[k] !== 1'b1 && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check8({7'h00, ev[k]}, 8'h01);
  end
  endtask
  task automatic check_len(input logic [9:0] got, input logic [9:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %0d cycles want %0d", $time, got, exp);
    end
  end
  endtask
  // count edges while one event bit stays at a level
  task automatic count_ev(input int k, input logic lvl, input int lim,
    output logic [9:0] n);
  begin
    n = 10'd0;
    while (ev[k] === lvl && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  end
  endtask
  task automatic t_reset;
  begin
    rc(16'hffa8, 8'h00);
    rc(16'hffa9, 8'h00);
    rc(16'hffea, 8'h00);
    rc(16'hffeb, 8'h00);
    rc(16'hffc4, 8'h09);
    u_cpu.wr16(16'hffc4, 16'h00f6, 1'b0);
    rc(16'hffc4, 8'hde);
    u_cpu.wr16(16'hffc4, 16'h0001, 1'b0);
    rc(16'hffc4, 8'h09);
    rc(16'h0000, 8'h00);
    $display("done reset");
  end
  endtask
  task automatic t_keys;
  begin
    u_cpu.wr16(16'hffa8, 16'ha527, 1'b1);
    rc(16'hffa8, 8'h27);
    u_cpu.wr16(16'hffa8, 16'ha500, 1'b0);
    u_cpu.wr16(16'hffa8, 16'h5b00, 1'b1);
    rc(16'hffa8, 8'h27);
    u_cpu.wr16(16'hffa8, 16'h5a80, 1'b1);
    rc(16'hffa9, 8'h80);
    u_cpu.wr16(16'hffa8, 16'ha507, 1'b1);
    u_cpu.wr16(16'hffa8, 16'h5a33, 1'b1);
    rc(16'hffa9, 8'h00);
    u_cpu.wr16(16'hffa8, 16'ha587, 1'b1);
    rc(16'hffa8, 8'h07);
    $display("done keys");
  end
  endtask
  task automatic t_interval;
  begin
    u_cpu.wr16(16'hffa8, 16'ha520, 1'b1);
    u_cpu.wr16(16'hffa8, 16'h5afe, 1'b1);
    wait_ev(0, 40);
    rc(16'hffa8, 8'ha0);
    rc(16'hffa8, 8'ha0);
    u_cpu.wr16(16'hffa8, 16'ha520, 1'b1);
    rc(16'hffa8, 8'h20);
    u_cpu.wr16(16'hffa8, 16'h5afe, 1'b1);
    wait_ev(0, 40);
    u_cpu.wr16(16'hffa8, 16'ha500, 1'b1);
    rc(16'hffa8, 8'h00);
    $display("done interval");
  end
  endtask
  task automatic t_standby;
  begin
    @(posedge ref_clk);
    sw_standby <= 1'b1;
    u_cpu.wr16(16'hffa8, 16'ha520, 1'b1);
    u_cpu.wr16(16'hffa8, 16'h5a44, 1'b1);
    repeat (20) @(posedge ref_clk);
    rc(16'hffa9, 8'h44);
    rc(16'hffa8, 8'h20);
    @(posedge ref_clk);
    sw_standby <= 1'b0;
    u_cpu.wr16(16'hffa8, 16'ha500, 1'b1);
    $display("done standby");
  end
  endtask
  task automatic t_taps;
    logic [9:0] n;
  begin
    u_cpu.wr16(16'hffa8, 16'ha521, 1'b1);
    u_cpu.wr16(16'hffa8, 16'h5afe, 1'b1);
    wait_ev(0, 200);
    // preload ff just after a wrap; the write itself takes two cycles
    u_cpu.wr16(16'hffa8, 16'h5aff, 1'b1);
    count_ev(0, 1'b0, 100, n);
    check_len(n, 10'd62);
    u_cpu.wr16(16'hffa8, 16'ha500, 1'b1);
    $display("done taps");
  end
  endtask
  task automatic t_channel_one;
  begin
    u_cpu.wr16(16'hffea, 16'ha560, 1'b1);
    u_cpu.wr16(16'hffea, 16'h5afe, 1'b1);
    wait_ev(3, 40);
    rc(16'hffea, 8'he0);
    u_cpu.wr16(16'hffea, 16'ha530, 1'b1);
    u_cpu.wr16(16'hffea, 16'h5afe, 1'b1);
    wait_ev(1, 300);
    u_cpu.wr16(16'hffea, 16'ha500, 1'b1);
    $display("done channel one");
  end
  endtask
  task automatic t_watchdog;
    logic [9:0] n;
  begin
    u_cpu.wr16(16'hffa8, 16'ha568, 1'b1);
    u_cpu.wr16(16'hffa8, 16'h5afe, 1'b1);
    wait_ev(4, 40);
    @(posedge ref_clk);
    #1;
    count_ev(5, 1'b1, 600, n);
    check_len(n, 10'd518);
    rc(16'hffa8, 8'h68);
    rc(16'hffc4, 8'h01);
    u_cpu.wr16(16'hffa8, 16'ha525, 1'b1);
    @(posedge ref_clk);
    hw_standby <= 1'b1;
    @(posedge ref_clk);
    hw_standby <= 1'b0;
    rc(16'hffa8, 8'h00);
    $display("done watchdog");
  end
  endtask
  task automatic report_and_stop;
  begin
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_keys();
    t_interval();
    t_standby();
    t_taps();
    t_channel_one();
    t_watchdog();
    report_and_stop();
  end
endmodule
